// file: design/fsp_pkg.sv
// Purpose: Shared constants for the flash security and protection registers.
// Assumes: Avalon-MM slave, 32-bit data, byte addresses, one register per word.
// Notes: Reset values of the shadow registers come from the nonvolatile bytes.

package fsp_pkg;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [3:0] OFS_OPTION = 4'h0;
  localparam logic [3:0] OFS_CONFIG = 4'h4;
  localparam logic [3:0] OFS_PROTECT = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;

  // ==========================================================================
  // Option register fields
  localparam int OPT_BACKDOOR_KEY_ENABLE_BIT = 7;
  localparam int OPT_NORED_BIT = 6;
  localparam int OPT_SEC_MSB = 1;
  localparam logic [7:0] OPT_IMPL_MASK = 8'hC3;
  localparam logic [1:0] SEC_UNSECURED = 2'h2;

  // ==========================================================================
  // Configuration register fields
  localparam int CFG_KEY_WRITE_ENABLE_BIT = 5;
  localparam logic [7:0] CFG_IMPL_MASK = 8'hE0;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // ==========================================================================
  // Protection register fields
  localparam int PROT_DIS_BIT = 0;
  localparam int PROT_BLOCK_SHIFT = 9;
  localparam logic [8:0] PROT_BLOCK_FILL = 9'h1FF;

  // ==========================================================================
  // Status register fields
  localparam int STAT_SECURE_BIT = 0;
  localparam int STAT_VIOL_BIT = 1;
  localparam int STAT_MATCH_BIT = 2;

  // ==========================================================================
  // Backdoor key window
  localparam logic [15:0] KEY_BASE_ADDR = 16'hFFB0;
  localparam int KEY_BYTES = 8;

  // ==========================================================================
  // Load sequencer
  typedef enum logic [2:0] {
    FSP_ST_RESET = 3'b001,
    FSP_ST_LOAD = 3'b010,
    FSP_ST_RUN = 3'b100
  } fsp_state_e;

endpackage

// file: design/fsp_key_store.sv
// Purpose: Holds the backdoor comparison bytes written by user firmware.
// Assumes: One byte written per cycle at most; clear wins over a write.
// Notes: Stored key and written mask come straight out of registers.

`timescale 1ns/1ps
`default_nettype none

module fsp_key_store #(
  parameter int NBYTES = 8
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Write side
  input wire logic i_clear,
  input wire logic i_wr_en,
  input wire logic [2:0] i_wr_idx,
  input wire logic [7:0] i_wr_data,
  // Read side
  output logic [8*NBYTES-1:0] o_key,
  output logic [NBYTES-1:0] o_written
);

  // ==========================================================================
  // Storage
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_key <= '0;
      o_written <= '0;
    end else if (i_clear) begin
      o_written <= '0;
    end else if (i_wr_en) begin
      o_key[8*i_wr_idx +: 8] <= i_wr_data;
      o_written[i_wr_idx] <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// file: design/fsp_regs.sv
// Purpose: Flash option, configuration and protection registers with security.
// Assumes: All inputs come from logic on i_mclk; no synchronisers are needed.
// Notes: Nonvolatile option and protection bytes are copied on the second edge after reset release; the key is compared live.
//
// Summary of operation
// [R1] Reset loads option register from nonvolatile byte.
// [R2] Option bits 5 to 2 read zero.
// [R3] Option register readable, writes ignored.
// [R4] Key disabled means no backdoor unsecuring.
// [R5] Matching eight-byte key unsecures until reset.
// [R6] Debug-sourced key bytes are not accepted.
// [R7] Option bit 6 disables vector redirection.
// [R8] Only security pattern 1:0 means unsecured.
// [R9] Secure blocks memory access from unsecured sources.
// [R10] Key match or blank check sets 1:0.
// [R11] Config bits 7:5 read/write, 4:0 zero.
// [R12] Key-write enable steers key-window writes.
// [R13] Reset loads protection register from nonvolatile byte.
// [R14] Protection writable only by background debug.
// [R15] Select field sets unprotected high-end boundary.
// [R16] Protection bit 0 disables all protection.
// [R17] Protected commands ignored, violation flag set.
// [R18] Clearing key-write enable triggers key compare.
// [R19] Key-write enable sits at config bit 5.

`timescale 1ns/1ps
`default_nettype none

module fsp_regs (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Nonvolatile bytes from flash
  input wire logic [7:0] i_nv_option_byte,
  input wire logic [7:0] i_nv_protect_byte,
  input wire logic [63:0] i_nv_backdoor_key,
  // Avalon-MM slave
  input wire logic [3:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  input wire logic i_background_debug_mode,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // CPU writes into the flash address space
  input wire logic i_fw_valid,
  input wire logic [15:0] i_fw_addr,
  input wire logic [7:0] i_fw_data,
  input wire logic i_fw_from_debug,
  output logic o_fw_cmd_start,
  output logic [15:0] o_fw_cmd_addr,
  output logic [7:0] o_fw_cmd_data,
  // Registered erase or program commands
  input wire logic i_cmd_valid,
  input wire logic i_cmd_is_modify,
  input wire logic [15:0] i_cmd_addr,
  output logic o_cmd_go,
  output logic o_protection_violation_flag,
  // Blank check outcome
  input wire logic i_blank_check_done,
  input wire logic i_blank_all_erased,
  // Memory access gate
  input wire logic i_mem_req,
  input wire logic i_mem_req_unsecured_src,
  output logic o_mem_grant,
  output logic o_mem_blocked,
  // Status towards the core
  output logic o_secure,
  output logic o_vector_redirect_disable,
  output logic o_loaded
);

  // ==========================================================================
  // State and registers
  fsp_pkg::fsp_state_e state_reg;
  fsp_pkg::fsp_state_e state_next;
  logic [7:0] option_shadow_reg;
  logic [7:0] config_control_reg;
  logic [7:0] protect_shadow_reg;
  logic [1:0] security_state_reg;
  logic viol_reg;
  logic match_seen_reg;
  logic compare_pend_reg;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic fw_start_reg;
  logic [15:0] fw_addr_reg;
  logic [7:0] fw_data_reg;
  logic cmd_go_reg;
  logic grant_reg;
  logic blocked_reg;
  logic secure_reg;
  logic [63:0] key_stored;
  logic [7:0] key_written;

  // ==========================================================================
  // Load sequencer
  wire load_now = (state_reg == fsp_pkg::FSP_ST_LOAD);
  wire running = (state_reg == fsp_pkg::FSP_ST_RUN);

  always_comb begin
    case (state_reg)
      fsp_pkg::FSP_ST_RESET: state_next = fsp_pkg::FSP_ST_LOAD;
      fsp_pkg::FSP_ST_LOAD: state_next = fsp_pkg::FSP_ST_RUN;
      fsp_pkg::FSP_ST_RUN: state_next = fsp_pkg::FSP_ST_RUN;
      default: state_next = fsp_pkg::FSP_ST_RESET;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= fsp_pkg::FSP_ST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Bus decode
  wire bus_req = i_read || i_write;
  wire bus_fire = bus_req && !wait_reg;
  wire wr_fire = bus_fire && i_write;
  wire be0 = i_byteenable[0];
  wire sel_option = (i_address == fsp_pkg::OFS_OPTION);
  wire sel_config = (i_address == fsp_pkg::OFS_CONFIG);
  wire sel_protect = (i_address == fsp_pkg::OFS_PROTECT);
  wire sel_status = (i_address == fsp_pkg::OFS_STATUS);
  wire [7:0] wbyte = i_writedata[7:0];
  wire wr_config = wr_fire && sel_config && be0;
  wire wr_protect = wr_fire && sel_protect && be0 && i_background_debug_mode; // [R14]
  wire wr_status = wr_fire && sel_status && be0;
  wire viol_clear = wr_status && wbyte[fsp_pkg::STAT_VIOL_BIT];

  // ==========================================================================
  // Field views
  wire key_enable = option_shadow_reg[fsp_pkg::OPT_BACKDOOR_KEY_ENABLE_BIT];
  wire key_write_enable = config_control_reg[fsp_pkg::CFG_KEY_WRITE_ENABLE_BIT]; // [R19]
  wire protection_disable = protect_shadow_reg[fsp_pkg::PROT_DIS_BIT];
  wire [6:0] protect_boundary_select = protect_shadow_reg[7:1];
  wire [7:0] config_next = wbyte & fsp_pkg::CFG_IMPL_MASK; // [R11]
  wire key_write_enable_next = config_next[fsp_pkg::CFG_KEY_WRITE_ENABLE_BIT];
  wire key_write_enable_fall = wr_config && key_write_enable && !key_write_enable_next; // [R18]
  wire key_write_enable_rise = wr_config && !key_write_enable && key_write_enable_next;

  // Security is derived from the live field; only 1:0 is unsecured.
  wire is_secure = (security_state_reg != fsp_pkg::SEC_UNSECURED); // [R8]

  // ==========================================================================
  // Read data
  wire [7:0] option_view = {option_shadow_reg[7:6], 4'h0,
                            security_state_reg} & fsp_pkg::OPT_IMPL_MASK; // [R2]
  wire [7:0] status_view = {5'h00, match_seen_reg, viol_reg, is_secure};
  wire [7:0] read_byte = sel_option ? option_view :
                         sel_config ? config_control_reg :
                         sel_protect ? protect_shadow_reg :
                         sel_status ? status_view : 8'h00;

  // ==========================================================================
  // Bus handshake
  // A request is held one cycle with waitrequest high so that read data
  // always leave a register; the write lands on the waitrequest-low edge.
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wait_reg <= !(bus_req && wait_reg && running);
      if (bus_req && wait_reg && running) begin
        rdata_reg <= {24'h00_0000, read_byte};
      end
    end
  end

  // ==========================================================================
  // Option and protection shadows
  // Writes to the option shadow have no path here at all.
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      option_shadow_reg <= 8'h00;
      protect_shadow_reg <= 8'h00;
    end else if (load_now) begin
      option_shadow_reg <= i_nv_option_byte & fsp_pkg::OPT_IMPL_MASK; // [R1] [R3]
      protect_shadow_reg <= i_nv_protect_byte; // [R13]
    end else if (wr_protect) begin
      protect_shadow_reg <= wbyte; // [R14]
    end
  end

  // ==========================================================================
  // Configuration register
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      config_control_reg <= fsp_pkg::CFG_RESET;
    end else if (wr_config) begin
      config_control_reg <= config_next; // [R11]
    end
  end

  // ==========================================================================
  // Key window steering
  wire in_key_window = (i_fw_addr[15:3] == fsp_pkg::KEY_BASE_ADDR[15:3]);
  wire key_path = i_fw_valid && in_key_window && key_write_enable; // [R12]
  wire key_wr = key_path && !i_fw_from_debug; // [R6]
  wire fw_to_cmd = i_fw_valid && !key_path; // [R12]

  fsp_key_store #(
    .NBYTES(fsp_pkg::KEY_BYTES)
  ) u_key_store (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_clear(key_write_enable_rise),
    .i_wr_en(key_wr),
    .i_wr_idx(i_fw_addr[2:0]),
    .i_wr_data(i_fw_data),
    .o_key(key_stored),
    .o_written(key_written)
  );

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      fw_start_reg <= 1'b0;
      fw_addr_reg <= 16'h0000;
      fw_data_reg <= 8'h00;
    end else begin
      fw_start_reg <= fw_to_cmd && running;
      if (fw_to_cmd) begin
        fw_addr_reg <= i_fw_addr;
        fw_data_reg <= i_fw_data;
      end
    end
  end

  // ==========================================================================
  // Key comparison
  // The compare waits one cycle so a byte written alongside the clearing
  // of key-write enable is already in the store.
  wire key_full = &key_written;
  wire key_equal = (key_stored == i_nv_backdoor_key);
  wire key_match = compare_pend_reg && key_enable && key_full && key_equal; // [R4] [R5]
  wire blank_unlock = i_blank_check_done && i_blank_all_erased;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      compare_pend_reg <= 1'b0;
      match_seen_reg <= 1'b0;
    end else begin
      compare_pend_reg <= key_write_enable_fall; // [R18]
      if (key_match) begin
        match_seen_reg <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Security field
  // Unsecuring lasts only until the next reset reloads the nonvolatile code.
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      security_state_reg <= 2'h0;
    end else if (load_now) begin
      security_state_reg <= i_nv_option_byte[fsp_pkg::OPT_SEC_MSB:0]; // [R1]
    end else if (key_match || blank_unlock) begin
      security_state_reg <= fsp_pkg::SEC_UNSECURED; // [R10] [R5]
    end
  end

  // ==========================================================================
  // Protection check
  wire [15:0] boundary = {protect_boundary_select, fsp_pkg::PROT_BLOCK_FILL}; // [R15]
  wire in_protected = (i_cmd_addr > boundary) && !protection_disable; // [R15] [R16]
  wire cmd_bad = i_cmd_valid && i_cmd_is_modify && in_protected; // [R17]
  wire cmd_ok = i_cmd_valid && !cmd_bad && running;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      viol_reg <= 1'b0;
      cmd_go_reg <= 1'b0;
    end else begin
      cmd_go_reg <= cmd_ok; // [R17]
      if (cmd_bad) begin
        viol_reg <= 1'b1; // [R17]
      end else if (viol_clear) begin
        viol_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Memory access gate
  wire mem_block = i_mem_req && i_mem_req_unsecured_src && is_secure; // [R9]

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      grant_reg <= 1'b0;
      blocked_reg <= 1'b0;
      secure_reg <= 1'b1;
    end else begin
      grant_reg <= i_mem_req && !mem_block && running;
      blocked_reg <= i_mem_req && (mem_block || !running); // [R9]
      secure_reg <= is_secure || !running; // [R8]
    end
  end

  // ==========================================================================
  // Outputs
  assign o_readdata = rdata_reg;
  assign o_waitrequest = wait_reg;
  assign o_fw_cmd_start = fw_start_reg;
  assign o_fw_cmd_addr = fw_addr_reg;
  assign o_fw_cmd_data = fw_data_reg;
  assign o_cmd_go = cmd_go_reg;
  assign o_protection_violation_flag = viol_reg;
  assign o_mem_grant = grant_reg;
  assign o_mem_blocked = blocked_reg;
  assign o_secure = secure_reg;
  assign o_vector_redirect_disable = option_shadow_reg[fsp_pkg::OPT_NORED_BIT]; // [R7]
  assign o_loaded = state_reg[2];

endmodule

`default_nettype wire

// file: tb/fsp_regs_asserts.sv
// Purpose: Port-level checks for the flash security and protection registers.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Bound to every instance of the register block.
`timescale 1ns/1ps
`default_nettype none
module fsp_regs_asserts (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Stimulus seen at the block
  input wire logic [3:0] i_address,
  input wire logic i_read,
  input wire logic i_fw_valid,
  input wire logic [15:0] i_fw_addr,
  input wire logic [7:0] i_fw_data,
  input wire logic i_cmd_valid,
  input wire logic i_cmd_is_modify,
  input wire logic i_blank_check_done,
  input wire logic i_blank_all_erased,
  input wire logic i_mem_req,
  input wire logic i_mem_req_unsecured_src,
  // Answers of the block
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  input wire logic o_fw_cmd_start,
  input wire logic [15:0] o_fw_cmd_addr,
  input wire logic [7:0] o_fw_cmd_data,
  input wire logic o_cmd_go,
  input wire logic o_protection_violation_flag,
  input wire logic o_mem_grant,
  input wire logic o_mem_blocked,
  input wire logic o_secure,
  input wire logic o_vector_redirect_disable,
  input wire logic o_loaded
);
  // ====
  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  // Read data is judged only while the master still holds its address.
  wire opt_rd = !o_waitrequest && i_read && i_address == fsp_pkg::OFS_OPTION;
  wire cfg_rd = !o_waitrequest && i_read && i_address == fsp_pkg::OFS_CONFIG;
  chk_unloaded_quiet: assert property (!o_loaded
    |-> o_waitrequest && !o_cmd_go && !o_fw_cmd_start)
    else $error("activity before shadows loaded");
  chk_opt_reserved: assert property (opt_rd |-> o_readdata[5:2] == 4'h0)
    else $error("option bits 5 to 2 not zero");
  chk_opt_redirect: assert property (opt_rd |-> o_readdata[6] == o_vector_redirect_disable)
    else $error("redirect output differs from option bit 6");
  chk_cfg_reserved: assert property (cfg_rd |-> o_readdata[4:0] == 5'h00)
    else $error("config bits 4 to 0 not zero");
  // The secure output trails the live state by one edge, so it is read alongside the answer.
  chk_mem_blocked: assert property (i_mem_req && i_mem_req_unsecured_src ##1 o_secure
    |-> o_mem_blocked && !o_mem_grant)
    else $error("unsecured access not blocked");
  chk_cmd_answer: assert property (o_loaded && i_cmd_valid
    |=> o_cmd_go || o_protection_violation_flag)
    else $error("command neither started nor flagged");
  chk_cmd_plain: assert property (o_loaded && i_cmd_valid && !i_cmd_is_modify |=> o_cmd_go)
    else $error("non-modifying command refused");
  chk_fw_echo: assert property (o_fw_cmd_start |-> $past(i_fw_valid)
    && o_fw_cmd_addr == $past(i_fw_addr) && o_fw_cmd_data == $past(i_fw_data))
    else $error("forwarded flash write differs from its cause");
  chk_fw_outside: assert property (o_loaded && i_fw_valid && i_fw_addr[15:3] != 13'h1FF6
    |=> o_fw_cmd_start)
    else $error("flash write outside key window not forwarded");
  chk_blank_unlock: assert property (o_loaded && i_blank_check_done && i_blank_all_erased
    |-> ##2 !o_secure)
    else $error("erased blank check left device secure");
  cov_unlock: cover property ($fell(o_secure));
  cov_violation: cover property ($rose(o_protection_violation_flag));
  cov_blocked: cover property (o_mem_blocked);
  cov_forward: cover property (o_fw_cmd_start);
endmodule
bind fsp_regs fsp_regs_asserts u_fsp_regs_asserts (.i_mclk, .i_nrst, .i_address, .i_read,
  .i_fw_valid, .i_fw_addr, .i_fw_data, .i_cmd_valid, .i_cmd_is_modify, .i_blank_check_done,
  .i_blank_all_erased, .i_mem_req, .i_mem_req_unsecured_src, .o_readdata, .o_waitrequest,
  .o_fw_cmd_start, .o_fw_cmd_addr, .o_fw_cmd_data, .o_cmd_go, .o_protection_violation_flag,
  .o_mem_grant, .o_mem_blocked, .o_secure, .o_vector_redirect_disable, .o_loaded);
`default_nettype wire

// file: tb/fsp_regs_tb.sv
// Purpose: Self-checking bench for the flash security and protection registers.
// Assumes: Shadows load two edges after reset release.
// Notes: A second reset reloads a different option byte.
`timescale 1ns/1ps
`default_nettype none
module fsp_regs_tb;
  // ====
  // Signals
  typedef struct packed {
    logic [3:0] a;
    logic w;
    logic d;
    logic be;
    logic [7:0] wd;
    logic [7:0] e;
  } fsp_row_s;
  localparam logic [63:0] KEY = 64'h0123456789ABCDEF;
  logic i_mclk = 1'b0;
  logic i_nrst, i_read, i_write, i_background_debug_mode, i_fw_valid, i_fw_from_debug;
  logic i_cmd_valid, i_cmd_is_modify, i_blank_check_done, i_blank_all_erased;
  logic i_mem_req, i_mem_req_unsecured_src, o_waitrequest, o_fw_cmd_start, o_cmd_go;
  logic o_protection_violation_flag, o_mem_grant, o_mem_blocked, o_secure;
  logic o_vector_redirect_disable, o_loaded;
  logic [7:0] i_nv_option_byte, i_nv_protect_byte, i_fw_data, o_fw_cmd_data;
  logic [63:0] i_nv_backdoor_key;
  logic [3:0] i_address, i_byteenable;
  logic [31:0] i_writedata, o_readdata, rd;
  logic [15:0] i_fw_addr, i_cmd_addr, o_fw_cmd_addr;
  logic [1:0] r;
  int failures = 0;
  int checks = 0;
  // Writes to option, user writes to protection and writes without lane 0 must not stick.
  fsp_row_s rows [15] = '{'{4'h0, 0, 0, 1, 8'h00, 8'hC1}, '{4'h0, 1, 0, 1, 8'hFF, 8'h00},
    '{4'h0, 0, 0, 1, 8'h00, 8'hC1}, '{4'h4, 1, 0, 1, 8'hFF, 8'h00},
    '{4'h4, 0, 0, 1, 8'h00, 8'hE0}, '{4'h4, 1, 0, 1, 8'h40, 8'h00},
    '{4'h4, 0, 0, 1, 8'h00, 8'h40}, '{4'h8, 0, 0, 1, 8'h00, 8'h0E},
    '{4'h8, 1, 0, 1, 8'h01, 8'h00}, '{4'h8, 0, 0, 1, 8'h00, 8'h0E},
    '{4'h8, 1, 1, 1, 8'h1E, 8'h00}, '{4'h8, 0, 0, 1, 8'h00, 8'h1E},
    '{4'h4, 1, 0, 0, 8'h80, 8'h00}, '{4'h4, 0, 0, 1, 8'h00, 8'h40},
    '{4'h2, 0, 0, 1, 8'h00, 8'h00}};
  fsp_regs u_fsp_regs (.i_mclk, .i_nrst, .i_nv_option_byte, .i_nv_protect_byte,
    .i_nv_backdoor_key, .i_address, .i_read, .i_write, .i_writedata, .i_byteenable,
    .i_background_debug_mode, .o_readdata, .o_waitrequest, .i_fw_valid, .i_fw_addr, .i_fw_data,
    .i_fw_from_debug, .o_fw_cmd_start, .o_fw_cmd_addr, .o_fw_cmd_data, .i_cmd_valid,
    .i_cmd_is_modify, .i_cmd_addr, .o_cmd_go, .o_protection_violation_flag,
    .i_blank_check_done, .i_blank_all_erased, .i_mem_req, .i_mem_req_unsecured_src,
    .o_mem_grant, .o_mem_blocked, .o_secure, .o_vector_redirect_disable, .o_loaded);
  always #20 i_mclk = ~i_mclk;
  // ====
  // Tasks
  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic [3:0] a, input logic w, input logic d, input logic be,
    input logic [7:0] wd);
    i_address <= a;
    i_write <= w;
    i_read <= !w;
    i_background_debug_mode <= d;
    i_byteenable <= {3'h0, be};
    i_writedata <= {24'h0, wd};
    @(posedge i_mclk);
    // Only the watchdog may end this wait; the request stands until answered.
    while (o_waitrequest !== 1'b0) begin
      @(posedge i_mclk);
    end
    rd = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
    @(posedge i_mclk);
  endtask
  // Kinds: 0 flash write, 1 command, 2 memory access, 3 blank check result.
  task automatic side(input int k, input logic [15:0] a, input logic [7:0] dt, input logic q);
    {i_fw_addr, i_cmd_addr, i_fw_data} <= {a, a, dt};
    {i_fw_from_debug, i_cmd_is_modify, i_mem_req_unsecured_src, i_blank_all_erased} <= {4{q}};
    {i_fw_valid, i_cmd_valid, i_mem_req, i_blank_check_done} <= 4'h8 >> k;
    @(posedge i_mclk);
    {i_fw_valid, i_cmd_valid, i_mem_req, i_blank_check_done} <= 4'h0;
    @(posedge i_mclk);
    if (k == 0) r = {o_fw_cmd_start, 1'b0};
    else if (k == 1) r = {o_cmd_go, o_protection_violation_flag};
    else r = {o_mem_grant, o_mem_blocked};
  endtask
  task automatic unlock();
    bus(4'h4, 1, 0, 1, 8'h20);
    for (int i = 0; i < 8; i++) begin
      side(0, {13'h1FF6, 3'(i)}, KEY[8*i +: 8], 0);
      chk("fw_start", 0, r);
    end
    // A debug-sourced wrong byte must be dropped, so the match still holds.
    side(0, 16'hFFB0, ~KEY[7:0], 1);
    chk("fw_start", 0, r);
    bus(4'h4, 1, 0, 1, 8'h00);
    repeat (4) @(posedge i_mclk);
  endtask
  task automatic rst(input logic [7:0] opt);
    i_nv_option_byte <= opt;
    i_nrst <= 1'b0;
    repeat (8) @(posedge i_mclk);
    chk("rst_secure", 1, o_secure);
    chk("rst_loaded", 0, o_loaded);
    chk("rst_wait", 1, o_waitrequest);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_mclk);
    chk("loaded", 1, o_loaded);
  endtask
  // ====
  // Sequence
  initial begin
    repeat (5000) @(posedge i_mclk);
    failures++;
    conclude();
  end
  initial begin
    {i_nrst, i_read, i_write, i_background_debug_mode, i_fw_valid, i_fw_from_debug} = '0;
    {i_cmd_valid, i_cmd_is_modify, i_blank_check_done, i_blank_all_erased} = '0;
    {i_mem_req, i_mem_req_unsecured_src, i_address, i_byteenable, i_writedata} = '0;
    {i_fw_addr, i_cmd_addr, i_fw_data, i_nv_option_byte} = '0;
    i_nv_protect_byte = 8'h0E;
    i_nv_backdoor_key = KEY;
    rst(8'hFD);
    for (int i = 0; i < 15; i++) begin
      bus(rows[i].a, rows[i].w, rows[i].d, rows[i].be, rows[i].wd);
      if (!rows[i].w) chk("readdata", {24'h0, rows[i].e}, rd);
    end
    chk("redirect", 1, o_vector_redirect_disable);
    chk("secure", 1, o_secure);
    side(2, 0, 0, 1);
    chk("mem", 2'b01, r);
    side(2, 0, 0, 0);
    chk("mem", 2'b10, r);
    side(1, 16'h2000, 0, 1);
    chk("cmd", 2'b01, r);
    side(1, 16'h1FFF, 0, 1);
    chk("cmd", 2'b11, r);
    bus(4'hC, 0, 0, 1, 0);
    chk("status", 3, rd);
    bus(4'hC, 1, 0, 1, 8'h02);
    side(1, 16'hFFFF, 0, 0);
    chk("cmd", 2'b10, r);
    bus(4'h8, 1, 1, 1, 8'h01);
    side(1, 16'hFFFF, 0, 1);
    chk("cmd", 2'b10, r);
    unlock();
    chk("secure", 0, o_secure);
    bus(4'h0, 0, 0, 1, 0);
    chk("option", 8'hC2, rd);
    bus(4'hC, 0, 0, 1, 0);
    chk("status", 4, rd);
    side(2, 0, 0, 1);
    chk("mem", 2'b10, r);
    side(0, 16'hFFB3, 8'h5A, 0);
    chk("fw_start", 2'b10, r);
    chk("fw_addr", 16'hFFB3, o_fw_cmd_addr);
    chk("fw_data", 8'h5A, o_fw_cmd_data);
    side(0, 16'h1234, 8'hA5, 0);
    chk("fw_start", 2'b10, r);
    chk("fw_addr", 16'h1234, o_fw_cmd_addr);
    chk("fw_data", 8'hA5, o_fw_cmd_data);
    rst(8'h01);
    chk("redirect", 0, o_vector_redirect_disable);
    unlock();
    chk("secure", 1, o_secure);
    side(3, 0, 0, 0);
    repeat (2) @(posedge i_mclk);
    chk("secure", 1, o_secure);
    side(3, 0, 0, 1);
    repeat (2) @(posedge i_mclk);
    chk("secure", 0, o_secure);
    conclude();
  end
endmodule
`default_nettype wire
